// >>> hdl/acc_pkg.sv
// Purpose: constants for the comparator control block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: register offsets are chosen locally
package acc_pkg;
	localparam logic [7:0] ADDR_CMP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ADC_CSB = 8'h04;
	localparam logic [7:0] ADDR_PIN_DIS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	// control/status field positions
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_IRQ_EN = 3;
	localparam int BIT_CAPTURE = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_MUX_EN = 6;
	localparam int BIT_NEG_BUF_OFF = 1;
	localparam int BIT_POS_BUF_OFF = 0;
	// writable masks
	localparam logic [7:0] CTRL_WMASK = 8'hCF;
	localparam logic [7:0] ADC_CSB_WMASK = 8'h47;
	localparam logic [7:0] PIN_DIS_WMASK = 8'h03;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] STAT_MASK_W = 2'h3;
	// irq mode codes
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_RSVD = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SYNC_STAGES = 2;
endpackage : acc_pkg

// >>> hdl/acc_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: async input, single clock
// Notes: first stage feeds only the second
module acc_sync (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// data
	input wire logic din,
	output logic dout
);
	logic [acc_pkg::SYNC_STAGES-1:0] stage_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stage_r <= '0;
		else
			stage_r <= {stage_r[acc_pkg::SYNC_STAGES-2:0], din};
	end

	assign dout = stage_r[acc_pkg::SYNC_STAGES-1];
endmodule : acc_sync

// >>> hdl/acc_top.sv
// Purpose: control and event logic around an on-chip voltage comparator
// Assumes: analog compare done outside; raw result arrives on cmp_raw
// Notes: registers over axi4-lite, one aligned word each
module acc_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// comparator analog side
	input wire logic cmp_raw,
	output logic comparator_power_off,
	output logic bandgap_positive_select,
	output logic neg_use_channel,
	output logic [2:0] neg_channel,
	// converter side
	input wire logic converter_enable,
	input wire logic [2:0] channel_select,
	output logic [2:0] trigger_source_sel,
	// pins
	input wire logic positive_input_pin,
	input wire logic negative_input_pin,
	output logic positive_pin_in,
	output logic negative_pin_in,
	output logic positive_pin_buffer_off,
	output logic negative_pin_buffer_off,
	// timer capture and core interrupt
	output logic capture_src,
	output logic capture_route_enable,
	input wire logic global_irq_enable,
	input wire logic irq_ack,
	output logic cmp_irq_req,
	output logic irq
);
	logic [7:0] ctrl_r;
	logic [7:0] adc_csb_r;
	logic [7:0] pin_dis_r;
	logic flag_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic result_sync;
	logic result_prev_r;
	logic rise;
	logic fall;
	logic event_hit;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_fire;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;
	logic wr_lane0;
	logic wr_ctrl_hit;
	logic wr_stat_hit;
	logic [1:0] mode;
	logic [7:0] ctrl_read;

	// comparator itself is analog; raw already reflects pos > neg
	acc_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(cmp_raw),
		.dout(result_sync)
	);

	// previous synchronised sample for edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			result_prev_r <= 1'b0;
		else
			result_prev_r <= result_sync;
	end

	assign rise = result_sync & ~result_prev_r;
	assign fall = ~result_sync & result_prev_r;
	assign mode = ctrl_r[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO];

	always_comb
	begin
		case (mode)
			acc_pkg::MODE_TOGGLE: event_hit = rise | fall;
			acc_pkg::MODE_FALL: event_hit = fall;
			acc_pkg::MODE_RISE: event_hit = rise;
			// reserved code never flags
			acc_pkg::MODE_RSVD: event_hit = 1'b0;
			default: event_hit = 1'b0;
		endcase
	end

	// write channel capture; address and data in either order
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

	// byte lane 0 carries every register
	assign wr_lane0 = wr_fire && w_strb_r[0];
	assign wr_ctrl_hit = wr_lane0 && aw_addr_r == acc_pkg::ADDR_CMP_CTRL;
	assign wr_stat_hit = wr_lane0 && aw_addr_r == acc_pkg::ADDR_IRQ_STAT;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_got_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_got_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_got_r <= 1'b0;
	end

	always_comb
	begin
		case (aw_addr_r)
			acc_pkg::ADDR_CMP_CTRL,
			acc_pkg::ADDR_ADC_CSB,
			acc_pkg::ADDR_PIN_DIS,
			acc_pkg::ADDR_IRQ_STAT,
			acc_pkg::ADDR_IRQ_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= acc_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// configuration registers; only byte lane 0 carries data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= acc_pkg::REG_RESET;
			adc_csb_r <= acc_pkg::REG_RESET;
			pin_dis_r <= acc_pkg::REG_RESET;
			mask_r <= 2'h0;
		end
		else if (wr_lane0)
		begin
			case (aw_addr_r)
				acc_pkg::ADDR_CMP_CTRL: ctrl_r <= w_data_r[7:0] & acc_pkg::CTRL_WMASK;
				acc_pkg::ADDR_ADC_CSB: adc_csb_r <= w_data_r[7:0] & acc_pkg::ADC_CSB_WMASK;
				acc_pkg::ADDR_PIN_DIS: pin_dis_r <= w_data_r[7:0] & acc_pkg::PIN_DIS_WMASK;
				acc_pkg::ADDR_IRQ_MASK: mask_r <= w_data_r[1:0] & acc_pkg::STAT_MASK_W;
				default: ;
			endcase
		end
	end

	// flag: set wins over ack and write-one clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_r <= 1'b0;
		else if (event_hit)
			flag_r <= 1'b1;
		else if (irq_ack)
			flag_r <= 1'b0;
		else if (wr_ctrl_hit && w_data_r[acc_pkg::BIT_FLAG])
			flag_r <= 1'b0;
	end

	// sticky status: bit0 edge event, bit1 result rise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stat_r <= 2'h0;
		else if (wr_stat_hit)
			stat_r <= (stat_r & ~w_data_r[1:0]) | {rise, event_hit};
		else
			stat_r <= stat_r | {rise, event_hit};
	end

	// one level output for all unmasked status bits
	assign irq = |(stat_r & mask_r);

	// are software duties; no hardware guard
	assign cmp_irq_req = flag_r && ctrl_r[acc_pkg::BIT_IRQ_EN] && global_irq_enable;

	assign ctrl_read = {ctrl_r[7:6], result_sync, flag_r, ctrl_r[3:0]};

	// reads have no side effects
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			acc_pkg::ADDR_CMP_CTRL: rd_val = {24'h00_0000, ctrl_read};
			acc_pkg::ADDR_ADC_CSB: rd_val = {24'h00_0000, adc_csb_r};
			acc_pkg::ADDR_PIN_DIS: rd_val = {24'h00_0000, pin_dis_r};
			acc_pkg::ADDR_IRQ_STAT: rd_val = {30'h0000_0000, stat_r};
			acc_pkg::ADDR_IRQ_MASK: rd_val = {30'h0000_0000, mask_r};
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= acc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// analog steering
	assign comparator_power_off = ctrl_r[acc_pkg::BIT_POWER_OFF];
	assign bandgap_positive_select = ctrl_r[acc_pkg::BIT_BANDGAP];
	assign neg_use_channel = adc_csb_r[acc_pkg::BIT_MUX_EN] && !converter_enable;
	assign neg_channel = channel_select;
	assign trigger_source_sel = adc_csb_r[2:0];

	// capture unit adds its own filter and edge select
	assign capture_route_enable = ctrl_r[acc_pkg::BIT_CAPTURE];
	assign capture_src = capture_route_enable & result_sync;

	assign positive_pin_buffer_off = pin_dis_r[acc_pkg::BIT_POS_BUF_OFF];
	assign negative_pin_buffer_off = pin_dis_r[acc_pkg::BIT_NEG_BUF_OFF];
	assign positive_pin_in = positive_input_pin & ~positive_pin_buffer_off;
	assign negative_pin_in = negative_input_pin & ~negative_pin_buffer_off;
endmodule : acc_top

// >>> test/acc_analog.sv
// Purpose: analog comparator and pin levels
// Assumes: levels as 8-bit codes
// Notes: bandgap level is arbitrary
module acc_analog (
	// selection from the block
	input wire logic comparator_power_off,
	input wire logic bandgap_positive_select,
	input wire logic neg_use_channel,
	input wire logic [2:0] neg_channel,
	// analog levels
	input wire logic [7:0] pos_lvl,
	input wire logic [7:0] neg_lvl,
	input wire logic [63:0] chan_lvl,
	// raw result
	output logic cmp_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] BG_LVL = 8'h80;
	logic [7:0] p;
	logic [7:0] n;
	assign p = bandgap_positive_select ? BG_LVL : pos_lvl;
	assign n = neg_use_channel ? chan_lvl[neg_channel*8 +: 8] : neg_lvl;
	assign cmp_raw = !comparator_power_off && (p > n);
endmodule : acc_analog

// >>> test/acc_sva.sv
// Purpose: port-level checks for acc_top
// Assumes: one clock, sync active-low reset
// Notes: bound into every acc_top instance
module acc_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched ports
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic cmp_raw,
	input wire logic converter_enable,
	input wire logic neg_use_channel,
	input wire logic [2:0] channel_select,
	input wire logic [2:0] neg_channel,
	input wire logic positive_input_pin,
	input wire logic positive_pin_in,
	input wire logic positive_pin_buffer_off,
	input wire logic negative_input_pin,
	input wire logic negative_pin_in,
	input wire logic negative_pin_buffer_off,
	input wire logic capture_src,
	input wire logic capture_route_enable,
	input wire logic global_irq_enable,
	input wire logic cmp_irq_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	neg_chan_a: assert property (neg_channel == channel_select)
		else $error("negative channel differs");
	conv_owns_a: assert property (converter_enable |-> !neg_use_channel)
		else $error("channel used while converter on");
	buf_off_a: assert property (positive_pin_buffer_off |-> !positive_pin_in)
		else $error("pin reads while buffer off");
	pin_pass_a: assert property (!positive_pin_buffer_off |->
		positive_pin_in == positive_input_pin) else $error("pin value lost");
	neg_off_a: assert property (negative_pin_buffer_off |-> !negative_pin_in)
		else $error("negative pin reads while buffer off");
	neg_pass_a: assert property (!negative_pin_buffer_off |->
		negative_pin_in == negative_input_pin) else $error("negative pin value lost");
	cap_off_a: assert property (!capture_route_enable |-> !capture_src)
		else $error("capture fed while route off");
	cap_sync_a: assert property (capture_route_enable && $past(capture_route_enable) |->
		capture_src == $past(cmp_raw, 2)) else $error("capture not synced result");
	irq_gate_a: assert property (!global_irq_enable |-> !cmp_irq_req)
		else $error("request without global enable");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule : acc_sva

bind acc_top acc_sva u_acc_sva (.*);

// >>> test/tb_top.sv
// Purpose: self-checking bench for acc_top
// Assumes: axi4-lite master, fixed-seed lfsr
// Notes: cmp_raw comes from acc_analog, fed with the bench's analog levels
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, converter_enable = 0, irq_ack = 0;
	logic positive_input_pin = 0, negative_input_pin = 0, global_irq_enable = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pos_lvl = 0, neg_lvl = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, lf = 32'h0000F0B0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] channel_select = 0, neg_channel, trigger_source_sel;
	logic [63:0] chan_lvl = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmp_raw;
	logic comparator_power_off, bandgap_positive_select, neg_use_channel, irq, cmp_irq_req;
	logic positive_pin_in, negative_pin_in, positive_pin_buffer_off, negative_pin_buffer_off;
	logic capture_src, capture_route_enable;
	logic rb;
	logic [3:0] pn;
	logic [5:0] st;
	int n_errors = 0, total_checks = 0;
	always #5 aclk = ~aclk;
	acc_top u_acc_top (.*);
	acc_analog u_acc_analog (.*);
	function automatic logic [31:0] nx(logic [31:0] x);
		for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
		return x;
	endfunction : nx
	function automatic logic res_exp(logic [7:0] c, logic m, logic e, logic [2:0] s);
		logic [7:0] p;
		logic [7:0] n;
		p = c[6] ? 8'h80 : pos_lvl;
		n = (m && !e) ? chan_lvl[s*8 +: 8] : neg_lvl;
		return !c[7] && p > n;
	endfunction : res_exp
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ta, tw, tq, tr;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tq = s_axi_arready;
			tr = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			rs = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tq) s_axi_arvalid <= 0;
			if (tr) break;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (i == 50)
		begin
			n_errors++;
			give_verdict();
		end
	endtask : bus
	task automatic lv(input logic [7:0] v);
		pos_lvl <= v;
		repeat (5) @(posedge aclk);
		@(negedge aclk);
	endtask : lv
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		for (int a = 0; a < 24; a += 4)
		begin
			bus(0, a[7:0], 0);
			chk("reset read", 0, q);
			chk("resp", (a < 20) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR, rs);
		end
		for (int k = 0; k < 16; k++)
		begin
			lf = nx(lf);
			bus(1, 8'h00, lf & 32'h000000C4);
			bus(1, 8'h04, (lf >> 8) & 32'h00000047);
			bus(1, 8'h08, (lf >> 16) & 32'h00000003);
			pos_lvl <= lf[7:0] ^ lf[31:24];
			neg_lvl <= lf[23:16];
			chan_lvl <= {lf, lf ^ 32'h5A5A5A5A};
			converter_enable <= lf[20];
			channel_select <= lf[27:25];
			positive_input_pin <= lf[28];
			negative_input_pin <= lf[29];
			repeat (4) @(posedge aclk);
			bus(0, 8'h00, 0);
			rb = res_exp(lf[7:0] & 8'hC4, lf[14], lf[20], lf[27:25]);
			chk("result", 32'(rb), 32'(q[5]));
			chk("ctrl bits", lf & 32'h000000C4, q & 32'h000000CF);
			st = {comparator_power_off, bandgap_positive_select, neg_use_channel, trigger_source_sel};
			chk("steering", 32'({lf[7:6], lf[14] & !lf[20], lf[10:8]}), 32'(st));
			pn = {negative_pin_buffer_off, positive_pin_buffer_off, negative_pin_in, positive_pin_in};
			chk("pins", 32'({lf[17:16], lf[29] & !lf[17], lf[28] & !lf[16]}), 32'(pn));
			bus(0, 8'h04, 0);
			chk("mux reg", (lf >> 8) & 32'h00000047, q);
			bus(0, 8'h08, 0);
			chk("pin reg", (lf >> 16) & 32'h00000003, q);
		end
		s_axi_wstrb <= 4'hE;
		bus(1, 8'h04, 32'h00000047);
		chk("lane resp", 32'(acc_pkg::RESP_OKAY), 32'(rs));
		bus(0, 8'h04, 0);
		chk("lane off", (lf >> 8) & 32'h00000047, q);
		s_axi_wstrb <= 4'hF;
		bus(1, 8'h04, 0);
		neg_lvl <= 8'h40;
		for (int m = 0; m < 4; m++)
		begin
			bus(1, 8'h00, m);
			lv(8'h00);
			bus(1, 8'h00, 32'h10 | m);
			lv(8'hFF);
			bus(0, 8'h00, 0);
			chk("flag rise", 32'(m == 0 || m == 3), 32'(q[4]));
			bus(1, 8'h00, 32'h10 | m);
			lv(8'h00);
			bus(0, 8'h00, 0);
			chk("flag fall", 32'(m == 0 || m == 2), 32'(q[4]));
		end
		global_irq_enable <= 1;
		bus(1, 8'h00, 32'h0000001B);
		lv(8'hFF);
		chk("request", 1, 32'(cmp_irq_req));
		bus(1, 8'h00, 32'h0000000B);
		@(negedge aclk);
		chk("flag kept", 1, 32'(cmp_irq_req));
		@(posedge aclk);
		irq_ack <= 1;
		@(posedge aclk);
		irq_ack <= 0;
		@(negedge aclk);
		chk("acked", 0, 32'(cmp_irq_req));
		bus(0, 8'h0C, 0);
		chk("status", 3, q);
		bus(1, 8'h10, 32'h00000001);
		@(negedge aclk);
		chk("irq on", 1, 32'(irq));
		bus(1, 8'h0C, 32'h00000003);
		@(negedge aclk);
		chk("irq off", 0, 32'(irq));
		bus(0, 8'h0C, 0);
		chk("status clr", 0, q);
		give_verdict();
	end
endmodule : tb_top
